// file: hw/ssr_consts.svh
// Offsets, field positions, reset values and timing counts for ssr_ctrl.
// Assumes a 100 MHz system clock and word-aligned byte addresses.
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

`define SSR_ADDR_W          8
`define SSR_DATA_W          32
`define SSR_CTRL_W          8
`define SSR_OFF_CTRL        8'h00
`define SSR_OFF_SOFT_RST    8'h04
`define SSR_OFF_STATUS      8'h08
`define SSR_BIT_SLEEP       2
`define SSR_BIT_INIT_PEND   7
`define SSR_CTRL_WR_MASK    8'h7f
`define SSR_CTRL_RST_VAL    8'h00
`define SSR_BIT_ST_SLEEPING 0
`define SSR_BIT_ST_SPEED_HI 1
`define SSR_BIT_ST_RUNNING  2
`define SSR_CLK_PERIOD_NS   10
`define SSR_RST_TIME_NS     100
`define SSR_RST_CYCLES \
    ((`SSR_RST_TIME_NS + `SSR_CLK_PERIOD_NS - 1) / `SSR_CLK_PERIOD_NS)
`define SSR_INIT_WORDS      256

`endif

// file: hw/ssr_pkg.sv
// Types shared by the sleep and soft reset controller.
// Assumes ssr_consts.svh is on the include path.
`include "ssr_consts.svh"

package ssr_pkg;

    typedef struct packed {
        logic [`SSR_ADDR_W-1:0] addr;
        logic [`SSR_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } ssr_bus_req_t;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_INIT,
        ST_RUN,
        ST_SLEEP
    } ssr_state_t;

endpackage

// file: hw/ssr_ctrl.sv
// Sleep, wake reset and software reset control for a glyph engine core.
// Assumes a synchronous register port on the system clock and a
// clock-speed strap pin that comes from outside the clock domain.
//
// Summary of operation
// R1: Control bit 2 set to one stops the core clock; sleep begins.
// R2: Core working data is not kept through sleep; only control stays.
// R3: Writing zero to control bit 2 ends sleep, clock restarts.
// R4: Leaving sleep applies an internal reset automatically.
// R5: Control register keeps its value across sleep and wake reset.
// R6: Host sets sleep only after its outline processing has finished.
// R7: Any write to the soft reset register resets; data ignored.
// R8: Soft reset is accepted at any time around other accesses.
// R9: Soft reset returns everything, control register too, to defaults.
// R10: After soft reset the host reprograms control if needed.
// R11: Strap high means fast host clock, low means slow host clock.
// R12: Hardware reset initialises registers then starts memory init.
// R13: Host polls control until the init pending flag reads zero.
// R14: Control register stays writable during sleep to clear the bit.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "ssr_consts.svh"

module ssr_ctrl
    import ssr_pkg::*;
#(
    parameter int RST_CYCLES = `SSR_RST_CYCLES,
    parameter int INIT_WORDS = `SSR_INIT_WORDS
) (
    input  wire                     i_ref_clk,
    input  wire                     i_sys_rst,
    input  ssr_bus_req_t            i_bus,
    input  wire                     i_clk_speed_select,
    output logic [`SSR_DATA_W-1:0]  o_rdata,
    output logic                    o_core_clk_en,
    output logic                    o_core_rst,
    output logic                    o_init_pending,
    output logic                    o_sleeping,
    output logic                    o_clk_speed_hi
);

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] RST_LAST  = CNT_W'(RST_CYCLES - 1);
    localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_WORDS - 1);

    ssr_state_t               state_ff;
    ssr_state_t               nxt_state;
    logic [CNT_W-1:0]         cnt_ff;
    logic [`SSR_CTRL_W-1:0]   ctrl_ff;
    logic [`SSR_DATA_W-1:0]   rdata_ff;
    logic                     clk_en_ff;
    logic                     core_rst_ff;
    logic                     init_pend_ff;
    logic                     sleeping_ff;
    logic                     speed_hi_ff;
    logic                     strap_meta_ff;
    logic                     strap_sync_ff;
    logic                     wr_ctrl;
    logic                     wr_soft;
    logic                     rd_hit;
    logic                     sleep_req;

    assign wr_ctrl   = i_bus.wr && (i_bus.addr == `SSR_OFF_CTRL);
    assign wr_soft   = i_bus.wr && (i_bus.addr == `SSR_OFF_SOFT_RST);
    assign rd_hit    = i_bus.rd;
    assign sleep_req = ctrl_ff[`SSR_BIT_SLEEP];

    // Strap is a pin, so it is synchronised before anyone looks at it
    always_ff @(posedge i_ref_clk) begin
        strap_meta_ff <= i_clk_speed_select;
        strap_sync_ff <= strap_meta_ff;
    end

    // Strap is latched while internal reset is active, then frozen
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            speed_hi_ff <= 1'b0;
        end else if (state_ff == ST_RESET) begin
            speed_hi_ff <= strap_sync_ff; // [R11]
        end
    end

    // Control register: soft reset clears it, wake reset does not
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ctrl_ff <= `SSR_CTRL_RST_VAL; // [R12]
        end else if (wr_soft) begin
            ctrl_ff <= `SSR_CTRL_RST_VAL; // [R9]
        end else if (wr_ctrl) begin
            // Writable in every state, sleep included [R14]
            ctrl_ff <= i_bus.wdata[`SSR_CTRL_W-1:0] & `SSR_CTRL_WR_MASK;
        end
    end

    // Sequencer: reset pulse, memory init, run, sleep
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RESET: begin
                if (cnt_ff == RST_LAST) begin
                    nxt_state = ST_INIT; // [R12]
                end
            end
            // Sleep during init abandons the sweep; wake redoes it
            ST_INIT: begin
                if (sleep_req) begin
                    nxt_state = ST_SLEEP; // [R1]
                end else if (cnt_ff == INIT_LAST) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_req) begin
                    nxt_state = ST_SLEEP; // [R1]
                end
            end
            ST_SLEEP: begin
                if (!sleep_req) begin
                    nxt_state = ST_RESET; // [R3] [R4]
                end
            end
            default: begin
                nxt_state = ST_RESET;
            end
        endcase
        // Soft reset wins over anything in flight
        if (wr_soft) begin
            nxt_state = ST_RESET; // [R7] [R8]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_ff <= ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // One counter serves both the reset pulse and the init sweep
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            cnt_ff <= '0;
        end else if (nxt_state != state_ff || wr_soft) begin
            cnt_ff <= '0;
        end else if (state_ff == ST_RESET || state_ff == ST_INIT) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end
    end

    // Outputs follow the next state so each comes from a flop
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            clk_en_ff    <= 1'b1;
            core_rst_ff  <= 1'b1;
            init_pend_ff <= 1'b1;
            sleeping_ff  <= 1'b0;
        end else begin
            // Gated core loses its data while stopped [R1] [R2]
            clk_en_ff    <= (nxt_state != ST_SLEEP);
            core_rst_ff  <= (nxt_state == ST_RESET); // [R4] [R9]
            init_pend_ff <= (nxt_state == ST_RESET) ||
                            (nxt_state == ST_INIT); // [R13]
            sleeping_ff  <= (nxt_state == ST_SLEEP);
        end
    end

    // Read port: data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rdata_ff <= '0;
        end else if (rd_hit) begin
            case (i_bus.addr)
                `SSR_OFF_CTRL: begin
                    rdata_ff <= '0;
                    rdata_ff[`SSR_CTRL_W-1:0] <= ctrl_ff;
                    rdata_ff[`SSR_BIT_INIT_PEND] <= init_pend_ff; // [R13]
                end
                `SSR_OFF_STATUS: begin
                    rdata_ff <= '0;
                    rdata_ff[`SSR_BIT_ST_SLEEPING] <= sleeping_ff;
                    rdata_ff[`SSR_BIT_ST_SPEED_HI] <= speed_hi_ff;
                    rdata_ff[`SSR_BIT_ST_RUNNING]  <= (state_ff == ST_RUN);
                end
                default: begin
                    // Soft reset register and holes read as zero
                    rdata_ff <= '0;
                end
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end

    assign o_rdata        = rdata_ff;
    assign o_core_clk_en  = clk_en_ff;
    assign o_core_rst     = core_rst_ff;
    assign o_init_pending = init_pend_ff;
    assign o_sleeping     = sleeping_ff;
    assign o_clk_speed_hi = speed_hi_ff;

    // Checks run only outside hardware reset
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_sleep_stops_clk: assert property ( // [R1]
        (wr_ctrl && i_bus.wdata[`SSR_BIT_SLEEP] && state_ff == ST_RUN)
        |=> ##1 (!o_core_clk_en || state_ff == ST_RESET))
        else $error("sleep write did not stop the core clock");

    a_sleep_no_clk: assert property ( // [R2]
        (state_ff == ST_SLEEP) |-> (!o_core_clk_en && o_sleeping))
        else $error("core clock running while asleep");

    a_wake_resets: assert property ( // [R3] [R4]
        (state_ff == ST_SLEEP && !sleep_req && !wr_soft)
        |=> (o_core_rst && o_core_clk_en && state_ff == ST_RESET))
        else $error("sleep exit without internal reset");

    // Wake reset must leave control alone; only host writes move it,
    // which is why the host need not program it again after waking
    a_ctrl_kept_wake: assert property ( // [R5]
        (state_ff inside {ST_SLEEP, ST_RESET, ST_INIT} && !wr_ctrl
         && !wr_soft) |=> $stable(ctrl_ff))
        else $error("control lost across wake reset");

    a_soft_clears: assert property ( // [R7] [R9]
        wr_soft |=> (ctrl_ff == `SSR_CTRL_RST_VAL && o_core_rst
                     && o_init_pending))
        else $error("soft reset did not clear control");

    // Pulse length follows the counter, so it scales with RST_CYCLES
    a_soft_holds: assert property ( // [R8] [R9]
        (state_ff == ST_RESET && cnt_ff != RST_LAST) |=> o_core_rst)
        else $error("soft reset pulse too short");

    a_reset_to_init: assert property ( // [R12]
        (state_ff == ST_RESET && cnt_ff == RST_LAST && !wr_soft)
        |=> (state_ff == ST_INIT && !o_core_rst && o_init_pending))
        else $error("memory init did not follow reset");

    a_init_flag_read: assert property ( // [R13]
        (rd_hit && i_bus.addr == `SSR_OFF_CTRL)
        |=> (o_rdata[`SSR_BIT_INIT_PEND] == $past(o_init_pending)))
        else $error("init pending flag misreported");

    a_sleep_write: assert property ( // [R14]
        (state_ff == ST_SLEEP && wr_ctrl) |=> (ctrl_ff ==
            ($past(i_bus.wdata[`SSR_CTRL_W-1:0]) & `SSR_CTRL_WR_MASK)))
        else $error("control write ignored during sleep");

    a_strap_frozen: assert property ( // [R11]
        (state_ff != ST_RESET) |=> $stable(o_clk_speed_hi))
        else $error("speed strap changed outside reset");

    a_init_sleep: assert property ( // [R1]
        (state_ff == ST_INIT && sleep_req && !wr_soft)
        |=> (state_ff == ST_SLEEP && !o_core_clk_en && o_sleeping))
        else $error("sleep request ignored during memory init");

    a_init_to_run: assert property ( // [R12] [R13]
        (state_ff == ST_INIT && cnt_ff == INIT_LAST && !sleep_req
         && !wr_soft)
        |=> (state_ff == ST_RUN && !o_init_pending))
        else $error("init pending still set after memory init");

    a_run_not_pend: assert property ( // [R13]
        (state_ff == ST_RUN) |-> !o_init_pending)
        else $error("init pending set while running");

    a_wake_pend: assert property ( // [R4]
        (state_ff == ST_SLEEP && !sleep_req && !wr_soft)
        |=> o_init_pending)
        else $error("wake reset did not restart memory init");

    a_soft_wakes: assert property ( // [R8]
        (state_ff == ST_SLEEP && wr_soft)
        |=> (state_ff == ST_RESET && o_core_clk_en && !o_sleeping))
        else $error("soft reset not taken during sleep");

    // Reset only bites if the core clock runs while it is applied
    a_rst_clk_on: assert property ( // [R4]
        o_core_rst |-> o_core_clk_en)
        else $error("core reset applied with clock stopped");

    a_rdata_idle: assert property ( // [R13]
        !rd_hit |=> (o_rdata == '0))
        else $error("read data not cleared after read cycle");

    a_status_read: assert property ( // [R11]
        (rd_hit && i_bus.addr == `SSR_OFF_STATUS)
        |=> (o_rdata[`SSR_BIT_ST_SLEEPING] == $past(o_sleeping)
             && o_rdata[`SSR_BIT_ST_SPEED_HI] == $past(o_clk_speed_hi)))
        else $error("status read does not match outputs");

    c_enter_sleep: cover property (
        (state_ff == ST_RUN) ##1 (state_ff == ST_SLEEP));
    c_wake_cycle: cover property (
        (state_ff == ST_SLEEP) ##1 (state_ff == ST_RESET)
        ##[1:40] (state_ff == ST_INIT));
    c_soft_in_init: cover property (
        (state_ff == ST_INIT && wr_soft));
    c_init_done: cover property (
        (state_ff == ST_INIT) ##1 (state_ff == ST_RUN));
    c_soft_in_sleep: cover property (
        (state_ff == ST_SLEEP && wr_soft));

endmodule // ssr_ctrl

// file: tb/ssr_host_model.sv
// Host model: drives the register port and the clock-speed strap.
// Assumes calls come from one bench process at a time.
`timescale 1ns/100ps
`include "ssr_consts.svh"
module ssr_host_model
    import ssr_pkg::*;
(
    input  wire                    i_ref_clk,
    input  wire [`SSR_DATA_W-1:0]  i_rdata,
    output ssr_bus_req_t           o_bus,
    output logic                   o_clk_speed_select
);
    initial begin
        o_bus = '0;
        o_clk_speed_select = 1'b1; // Fast host clock in use
    end

    task automatic set_strap(input logic s);
        @(posedge i_ref_clk);
        o_clk_speed_select <= s;
    endtask

    // Released lines carry inverted values, not the last ones
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_ref_clk);
        o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        o_bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge i_ref_clk);
        o_bus <= '{addr: ~a, wdata: '1, wr: 1'b0, rd: 1'b0};
        #1 d = i_rdata;
    endtask

    // Poll control until init pending clears; bounded
    task automatic wait_ready(output logic ok);
        logic [31:0] v;
        ok = 1'b0;
        for (int i = 0; i < 64 && !ok; i++) begin
            rd(`SSR_OFF_CTRL, v);
            ok = (v[`SSR_BIT_INIT_PEND] === 1'b0);
        end
    endtask
endmodule // ssr_host_model

// file: tb/tb_ssr_ctrl.sv
// Self-checking bench for ssr_ctrl: reset, sleep/wake, soft reset.
// Assumes ssr_host_model drives the register port and the strap.
`timescale 1ns/100ps
`include "ssr_consts.svh"
module tb_ssr_ctrl
    import ssr_pkg::*;
;
    logic               i_ref_clk = 1'b0;
    logic               i_sys_rst = 1'b1;
    ssr_bus_req_t       bus;
    logic               strap, clk_en, core_rst, pend, sleeping, spd_hi;
    logic [31:0]        rdata, v;
    int                 num_errors = 0;
    int                 tests_run = 0;

    always #5 i_ref_clk = ~i_ref_clk;

    // Short counts keep the run brief
    ssr_ctrl #(.RST_CYCLES(4), .INIT_WORDS(8)) u_dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_bus(bus),
        .i_clk_speed_select(strap), .o_rdata(rdata),
        .o_core_clk_en(clk_en), .o_core_rst(core_rst),
        .o_init_pending(pend), .o_sleeping(sleeping),
        .o_clk_speed_hi(spd_hi));
    ssr_host_model u_host (
        .i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_bus(bus),
        .o_clk_speed_select(strap));

    task automatic chk(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic t_reset;
        logic ok;
        chk("core_rst", core_rst, 1);
        chk("pend", pend, 1);
        u_host.wait_ready(ok);
        chk("ready", ok, 1);
        u_host.rd(`SSR_OFF_CTRL, v);
        chk("ctrl", v, `SSR_CTRL_RST_VAL);
        chk("core_rst", core_rst, 0);
        chk("speed_hi", spd_hi, 1);
        u_host.rd(`SSR_OFF_STATUS, v);
        chk("status", v, 32'h6);
        $display("test reset done");
    endtask

    task automatic t_sleep;
        logic ok;
        // Core is idle here, so sleep loses no work
        u_host.wr(`SSR_OFF_CTRL, 32'h25);
        tick(2);
        chk("clk_en", clk_en, 0);
        chk("sleeping", sleeping, 1);
        u_host.rd(`SSR_OFF_CTRL, v);
        chk("ctrl", v, 32'h25);
        u_host.wr(`SSR_OFF_CTRL, 32'h21);
        tick(2);
        chk("clk_en", clk_en, 1);
        chk("sleeping", sleeping, 0);
        chk("core_rst", core_rst, 1);
        chk("pend", pend, 1);
        u_host.rd(`SSR_OFF_CTRL, v);
        chk("ctrl", v, 32'ha1);
        u_host.wait_ready(ok);
        chk("ready", ok, 1);
        u_host.rd(`SSR_OFF_CTRL, v);
        chk("ctrl", v, 32'h21);
        $display("test sleep done");
    endtask

    task automatic t_soft;
        logic ok;
        for (int i = 0; i < 2; i++) begin
            u_host.set_strap(i[0]);
            u_host.wr(`SSR_OFF_CTRL, 32'h13);
            u_host.rd(`SSR_OFF_CTRL, v);
            chk("ctrl", v, 32'h13);
            u_host.wr(`SSR_OFF_SOFT_RST, i[0] ? '1 : '0);
            tick(1);
            chk("core_rst", core_rst, 1);
            u_host.rd(`SSR_OFF_CTRL, v);
            chk("ctrl", v, 32'h80);
            u_host.wait_ready(ok);
            chk("ready", ok, 1);
            chk("speed_hi", spd_hi, i[0]);
            u_host.rd(`SSR_OFF_CTRL, v);
            chk("ctrl", v, `SSR_CTRL_RST_VAL);
        end
        $display("test soft reset done");
    endtask

    // Soft reset in init and in sleep, sleep straight out of init
    task automatic t_sleep_init;
        logic ok;
        u_host.wr(`SSR_OFF_SOFT_RST, 32'h0);
        tick(5);
        u_host.wr(`SSR_OFF_SOFT_RST, 32'h5a);
        tick(1);
        chk("core_rst", core_rst, 1);
        chk("pend", pend, 1);
        u_host.wr(`SSR_OFF_CTRL, 32'h04);
        tick(4);
        chk("sleeping", sleeping, 1);
        chk("clk_en", clk_en, 0);
        u_host.rd(`SSR_OFF_CTRL, v);
        chk("ctrl", v, 32'h04);
        u_host.wr(`SSR_OFF_SOFT_RST, 32'h0);
        tick(1);
        chk("sleeping", sleeping, 0);
        chk("clk_en", clk_en, 1);
        chk("core_rst", core_rst, 1);
        u_host.wait_ready(ok);
        chk("ready", ok, 1);
        u_host.rd(`SSR_OFF_CTRL, v);
        chk("ctrl", v, `SSR_CTRL_RST_VAL);
        $display("test sleep during init done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #50us;
        num_errors++;
        $display("watchdog expired");
        results;
    end

    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        tick(1);
        t_reset;
        t_sleep;
        t_soft;
        t_sleep_init;
        results;
    end
endmodule // tb_ssr_ctrl
